// >>> acquisition_fifo_datapath_tb.sv
// acquisition_fifo_datapath_tb: host and device joined over the fast bus
// assumes: design files and afd_monitor compiled before this file
`timescale 1ns/1ps
module acquisition_fifo_datapath_tb
  import afd_pkg::*;
;
  logic        clk_i = 0;
  logic        reset_i = 1;
  logic        cmd_valid = 0;
  logic        cmd_write = 0;
  logic [5:0]  cmd_addr = 6'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        cmd_ready, rsp_valid, block_avail, ten_ref, xfer_ref;
  logic [15:0] rsp_data, src_data, q, v1, v2;
  logic [15:0] smp = 16'h0000;
  logic        smp_valid = 0;
  logic        trig = 0;
  logic        full_span = 0;
  logic        sync = 0;
  logic        tach = 0;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // clock and watchdog
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      complete_run();
    end
  end

  afd_fast_bus_if bus (.clk_i(clk_i));
  afd_device i_afd_device (.clk_i(clk_i), .reset_i(reset_i), .bus(bus),
    .converter_sample_data_i(smp), .sample_valid_i(smp_valid),
    .trigger_i(trig), .full_span_i(full_span),
    .measure_start_sync_i(sync), .buffered_tach_pulse_i(tach),
    .source_sample_data_o(src_data), .ten_mhz_ref_clock_o(ten_ref),
    .converter_xfer_ref_o(xfer_ref));
  afd_host i_afd_host (.clk_i(clk_i), .reset_i(reset_i), .bus(bus),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
    .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
    .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .block_avail_o(block_avail));
  afd_monitor i_afd_monitor (.clk_i(clk_i), .reset_i(reset_i),
    .fast_addr_lines(bus.fast_addr_lines), .fast_rd(bus.fast_rd),
    .fast_wr(bus.fast_wr), .fast_data_host_oe_n(bus.fast_data_host_oe_n),
    .fast_data_dev_oe_n(bus.fast_data_dev_oe_n), .fast_ack(bus.fast_ack),
    .block_ready_n(bus.block_ready_n));

  // compare one value and count it
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  // one command through the host port, waits for its completion
  task automatic bus_op(input logic wr, input logic [5:0] a,
                        input logic [15:0] d, output logic [15:0] r);
    int n;
    cmd_valid = 1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    tick();
    cmd_valid = 0;
    r = 16'h0000;
    n = 0;
    do begin
      tick();
      n++;
      if (rsp_valid === 1'b1) r = rsp_data;
    end while (cmd_ready !== 1'b1 && n < 20);
    check("command ready", 16'h0001, {15'h0000, cmd_ready});
  endtask

  // feed samples base, base+step, ... one every two cycles
  task automatic feed(input logic [15:0] base, input logic [15:0] step,
                      input int n);
    for (int i = 0; i < n; i++) begin
      smp = base + step * i[15:0];
      smp_valid = 1;
      tick();
      smp_valid = 0;
      tick();
    end
  endtask

  // wait a bounded time for the record flag
  task automatic wait_avail();
    for (int n = 0; n < 20 && block_avail !== 1'b1; n++) tick();
  endtask

  // reset state, decimation reset value and an unmapped read
  task automatic test_reset();
    check("block avail", 16'h0000, {15'h0000, block_avail});
    bus_op(0, AFD_A_STATUS, 16'h0000, q);
    check("status", 16'h0008, q);
    bus_op(0, AFD_A_DECIM, 16'h0000, q);
    check("decimation", AFD_DECIM_RST, q);
    bus_op(0, 6'h3F, 16'h0000, q);
    check("unmapped", 16'h0000, q);
    $display("test reset done");
  endtask

  // full span record: gated by trigger, drained in order, then rearmed
  task automatic test_record();
    full_span = 1;
    bus_op(1, AFD_A_DECIM, 16'h0000, q);
    bus_op(1, AFD_A_TRIG_POS, 16'h0000, q);
    bus_op(1, AFD_A_CONTROL, 16'h0002, q);
    feed(16'hDEAD, 16'h0000, 4);
    check("avail before trigger", 16'h0000, {15'h0000, block_avail});
    trig = 1;
    tick();
    feed(16'h0100, 16'h0001, 64);
    trig = 0;
    wait_avail();
    check("avail full", 16'h0001, {15'h0000, block_avail});
    for (int i = 0; i < 64; i++) begin
      bus_op(0, AFD_A_FIFO_DATA, 16'h0000, q);
      check("fifo sample", 16'h0100 + i[15:0], q);
    end
    tick();
    check("avail released", 16'h0000, {15'h0000, block_avail});
    bus_op(0, AFD_A_STATUS, 16'h0000, q);
    check("status rearmed", 16'h0009, q);
    $display("test record done");
  endtask

  // narrow span keeps every second sample, one point skipped after trigger
  task automatic test_decim();
    full_span = 0;
    bus_op(1, AFD_A_DECIM, 16'h0001, q);
    bus_op(1, AFD_A_TRIG_POS, 16'h0001, q);
    bus_op(1, AFD_A_CONTROL, 16'h0002, q);
    trig = 1;
    tick();
    feed(16'h1234, 16'h0000, 127);
    tick();
    check("avail early", 16'h0000, {15'h0000, block_avail});
    feed(16'h1234, 16'h0000, 3);
    trig = 0;
    wait_avail();
    check("avail decim", 16'h0001, {15'h0000, block_avail});
    for (int i = 0; i < 64; i++) begin
      bus_op(0, AFD_A_FIFO_DATA, 16'h0000, q);
      check("decim sample", 16'h1234, q);
    end
    $display("test decimation done");
  endtask

  // source ram loaded word by word, routed through the input mux
  task automatic test_source();
    full_span = 1;
    bus_op(1, AFD_A_SRC_ADDR, 16'h0000, q);
    for (int i = 0; i < 64; i++) begin
      bus_op(1, AFD_A_SRC_DATA, 16'hC3C3, q);
    end
    tick();
    check("source ram", 16'hC3C3, src_data);
    bus_op(1, AFD_A_TRIG_POS, 16'h0000, q);
    bus_op(1, AFD_A_CONTROL, 16'h0003, q);
    trig = 1;
    tick();
    feed(16'h0001, 16'h0000, 64);
    trig = 0;
    wait_avail();
    check("avail source", 16'h0001, {15'h0000, block_avail});
    for (int i = 0; i < 64; i++) begin
      bus_op(0, AFD_A_FIFO_DATA, 16'h0000, q);
      check("mux sample", 16'hC3C3, q);
    end
    bus_op(1, AFD_A_CONTROL, 16'h0004, q);
    tick();
    check("random source", 16'h0001,
          {15'h0000, src_data !== 16'hC3C3});
    $display("test source done");
  endtask

  // sync, n tach pulses each gap+1 cycles apart, read pointer and entry 15
  task automatic tach_run(input int n, input int gap, output logic [15:0] v);
    sync = 1;
    tick();
    sync = 0;
    repeat (n) begin
      repeat (gap) tick();
      tach = 1;
      tick();
      tach = 0;
    end
    bus_op(0, AFD_A_TACH_PTR, 16'h0000, q);
    check("tach pointer", 16'(n % 16), q);
    bus_op(0, AFD_A_TACH_DATA, 16'h0000, v);
  endtask

  // timestamps restart at sync and grow with pulse spacing
  task automatic test_tach();
    tach_run(3, 5, v1);
    tach_run(16, 4, v1);
    tach_run(16, 8, v2);
    check("tach spread", 16'h0040, v2 - v1);
    $display("test tach done");
  endtask

  // reference outputs counted over 400 cycles
  task automatic test_refs();
    int   t;
    int   x;
    logic pt;
    logic px;
    t = 0;
    x = 0;
    pt = ten_ref;
    px = xfer_ref;
    repeat (400) begin
      tick();
      if (ten_ref && !pt) t++;
      if (xfer_ref && !px) x++;
      pt = ten_ref;
      px = xfer_ref;
    end
    check("ten mhz rises", 16'h0028, t[15:0]);
    check("xfer ref rises", 16'h000A, x[15:0]);
    $display("test refs done");
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    #1 reset_i = 0;
    test_reset();
    test_record();
    test_decim();
    test_source();
    test_tach();
    test_refs();
    complete_run();
  end
endmodule

// >>> afd_device.sv
// afd_device: filter, record fifo, tach timestamps and source ram
// assumes: host keeps the fast bus protocol; inputs synchronous to clk_i
`timescale 1ns/1ps
module afd_device
  import afd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // fast bus
  afd_fast_bus_if.dev      bus,
  // sample inputs
  input  wire logic [15:0] converter_sample_data_i,
  input  wire logic        sample_valid_i,
  input  wire logic        trigger_i,
  input  wire logic        full_span_i,
  // tachometer
  input  wire logic        measure_start_sync_i,
  input  wire logic        buffered_tach_pulse_i,
  // source and references
  output logic      [15:0] source_sample_data_o,
  output logic             ten_mhz_ref_clock_o,
  output logic             converter_xfer_ref_o
);

  typedef struct packed {
    logic [15:0]        decim;
    logic [15:0]        control;
    logic [15:0]        trig_pos;
    logic [15:0]        decim_cnt;
    logic [31:0]        filt_acc;
    logic [15:0]        filt_latch;
    logic               filt_full;
    afd_fifo_state_type fst;
    logic [AFD_REC_W:0] wr_cnt;
    logic [AFD_REC_W-1:0] rd_ptr;
    logic [AFD_REC_W-1:0] wr_ptr;
    logic [15:0]        post_left;
    logic [15:0]        tach_cnt;
    logic [AFD_TACH_W-1:0] tach_ptr;
    logic [AFD_SRC_W-1:0]  src_addr;
    logic [AFD_SRC_W-1:0]  src_play;
    logic [15:0]        lfsr;
    logic [15:0]        pink;
    logic [15:0]        phase;
    logic [15:0]        src_out;
    logic [15:0]        out_latch;
    logic               ack;
    logic               oe_n;
    logic               blk_n;
    logic [3:0]         ten_div;
    logic [1:0]         xfer_div;
    logic               ten_clk;
    logic               xfer_ref;
  } afd_dev_state_type;

  afd_dev_state_type s_r, s_nxt;

  // working, record, tach and source memories
  logic [15:0] filt_ram [AFD_FILT_DEP];
  logic [15:0] fifo_ram [AFD_REC_LEN];
  logic [15:0] tach_ram [AFD_TACH_DEP];
  logic [15:0] src_ram  [AFD_SRC_DEP];

  logic [15:0] mux_data;
  logic        filt_emit;
  logic [31:0] filt_sum;
  logic        fifo_take;
  logic        tach_store;

  // input mux and filter datapath
  always_comb begin
    mux_data  = s_r.control[AFD_CTL_SRC_SEL] ? s_r.src_out
                                             : converter_sample_data_i;
    // two-tap average uses previous sample held in working ram
    filt_sum  = {16'h0000, mux_data} + {16'h0000, filt_ram[0]};
    filt_emit = sample_valid_i &&
                (full_span_i || s_r.decim_cnt == s_r.decim);
    // a finished record takes no further points, so entry 0 stays intact
    fifo_take = s_r.filt_full && s_r.fst == AFD_COLLECT &&
                !s_r.wr_cnt[AFD_REC_W];
    tach_store = buffered_tach_pulse_i && !measure_start_sync_i;
  end

  // next-state logic
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.oe_n = 1'b1;
    // clock references divided from the core clock
    if (s_r.ten_div == 4'(AFD_TEN_DIV / 2 - 1)) begin
      s_nxt.ten_div = 4'h0;
      s_nxt.ten_clk = !s_r.ten_clk;
      if (!s_r.ten_clk) begin
        s_nxt.xfer_div = s_r.xfer_div + 2'h1;
        s_nxt.xfer_ref = s_r.xfer_div == 2'(AFD_XFER_DIV - 1);
      end
    end else begin
      s_nxt.ten_div = s_r.ten_div + 4'h1;
    end
    // decimating filter stage
    if (sample_valid_i) begin
      s_nxt.decim_cnt = filt_emit ? 16'h0000 : s_r.decim_cnt + 16'h0001;
      s_nxt.filt_acc  = filt_sum;
    end
    if (filt_emit) begin
      s_nxt.filt_latch = full_span_i ? mux_data : filt_sum[16:1];
      s_nxt.filt_full  = 1'b1;
    end else if (fifo_take || s_r.fst != AFD_COLLECT) begin
      // a point latched before the trigger is dropped, never recorded
      s_nxt.filt_full  = 1'b0;
    end
    // fifo controller
    unique case (s_r.fst)
      AFD_IDLE: begin
        if (s_r.control[AFD_CTL_ARM]) begin
          s_nxt.fst       = AFD_ARMED;
          s_nxt.control[AFD_CTL_ARM] = 1'b0;
        end
      end
      AFD_ARMED: begin
        s_nxt.wr_cnt    = '0;
        s_nxt.wr_ptr    = '0;
        s_nxt.post_left = s_r.trig_pos;
        if (trigger_i) begin
          s_nxt.fst = AFD_COLLECT;
        end
      end
      AFD_COLLECT: begin
        // trigger position delays the record start by trig_pos points
        if (fifo_take) begin
          if (s_r.post_left != 16'h0000) begin
            s_nxt.post_left = s_r.post_left - 16'h0001;
          end else begin
            s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
            s_nxt.wr_cnt = s_r.wr_cnt + 1'b1;
          end
        end
        if (s_r.wr_cnt == (AFD_REC_W+1)'(AFD_REC_LEN)) begin
          s_nxt.fst    = AFD_DRAIN;
          s_nxt.rd_ptr = '0;
          s_nxt.blk_n  = 1'b0;
        end
      end
      AFD_DRAIN: begin
        if (bus.fast_rd && bus.fast_addr_lines == AFD_A_FIFO_DATA) begin
          s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
          if (s_r.rd_ptr == AFD_REC_W'(AFD_REC_LEN - 1)) begin
            s_nxt.blk_n = 1'b1;
            s_nxt.fst   = AFD_ARMED;
          end
        end
      end
    endcase
    // tachometer counter and timestamps
    if (measure_start_sync_i) begin
      s_nxt.tach_cnt = 16'h0000;
      s_nxt.tach_ptr = '0;
    end else begin
      s_nxt.tach_cnt = s_r.tach_cnt + 16'h0001;
      if (tach_store) begin
        s_nxt.tach_ptr = s_r.tach_ptr + 1'b1;
      end
    end
    // digital source generation
    s_nxt.lfsr  = {s_r.lfsr[14:0],
                   s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
    s_nxt.pink  = s_r.pink - (s_r.pink >>> 3) + (s_r.lfsr >>> 3);
    s_nxt.phase = s_r.phase + 16'h0400;
    s_nxt.src_play = s_r.src_play + 1'b1;
    unique case (s_r.control[AFD_CTL_SRC_MODE +: 2])
      2'b01:   s_nxt.src_out = s_r.lfsr;
      2'b10:   s_nxt.src_out = s_r.pink;
      2'b11:   s_nxt.src_out = s_r.phase[15] ? ~s_r.phase : s_r.phase;
      2'b00:   s_nxt.src_out = src_ram[s_r.src_play];
    endcase
    // fast bus slave: writes configure, reads answer next cycle
    if (bus.fast_wr) begin
      unique case (bus.fast_addr_lines)
        AFD_A_DECIM:    s_nxt.decim    = bus.fast_data_lines;
        AFD_A_CONTROL:  s_nxt.control  = bus.fast_data_lines;
        AFD_A_TRIG_POS: s_nxt.trig_pos = bus.fast_data_lines;
        AFD_A_SRC_ADDR: s_nxt.src_addr = bus.fast_data_lines[AFD_SRC_W-1:0];
        AFD_A_SRC_DATA: s_nxt.src_addr = s_r.src_addr + 1'b1;
        default: ;
      endcase
    end
    if (bus.fast_rd) begin
      s_nxt.ack  = 1'b1;
      s_nxt.oe_n = 1'b0;
      unique case (bus.fast_addr_lines)
        AFD_A_FIFO_DATA: s_nxt.out_latch = fifo_ram[s_r.rd_ptr];
        AFD_A_TACH_DATA: s_nxt.out_latch = tach_ram[bus.fast_data_lines[3:0]];
        AFD_A_TACH_PTR:  s_nxt.out_latch = 16'(s_r.tach_ptr);
        AFD_A_DECIM:     s_nxt.out_latch = s_r.decim;
        AFD_A_CONTROL:   s_nxt.out_latch = s_r.control;
        AFD_A_TRIG_POS:  s_nxt.out_latch = s_r.trig_pos;
        AFD_A_STATUS:    s_nxt.out_latch = {12'h000, s_r.blk_n, 1'b0,
                                            2'(s_r.fst)};
        default:         s_nxt.out_latch = 16'h0000;
      endcase
    end
  end

  // state register and memories
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r          <= '0;
      s_r.decim    <= AFD_DECIM_RST;
      s_r.control  <= AFD_CONTROL_RST;
      s_r.trig_pos <= AFD_TRIG_POS_RST;
      s_r.fst      <= AFD_IDLE;
      s_r.blk_n    <= 1'b1;
      s_r.oe_n     <= 1'b1;
      s_r.lfsr     <= 16'hACE1;
    end else begin
      s_r <= s_nxt;
    end
    if (sample_valid_i) begin
      filt_ram[0] <= mux_data;
    end
    if (fifo_take && s_r.post_left == 16'h0000) begin
      fifo_ram[s_r.wr_ptr] <= s_r.filt_latch;
    end
    if (tach_store) begin
      tach_ram[s_r.tach_ptr] <= s_r.tach_cnt;
    end
    if (bus.fast_wr && bus.fast_addr_lines == AFD_A_SRC_DATA) begin
      src_ram[s_r.src_addr] <= bus.fast_data_lines;
    end
  end

  // outputs straight from the state register
  assign bus.fast_data_dev      = s_r.out_latch;
  assign bus.fast_data_dev_oe_n = s_r.oe_n;
  assign bus.fast_ack           = s_r.ack;
  assign bus.block_ready_n      = s_r.blk_n;
  assign source_sample_data_o   = s_r.src_out;
  assign ten_mhz_ref_clock_o    = s_r.ten_clk;
  assign converter_xfer_ref_o   = s_r.xfer_ref;

endmodule

// >>> afd_fast_bus_if.sv
// afd_fast_bus_if: fast bus between device and host plus status lines
// assumes: both ends on clk_i; data lines resolved here from enables
`timescale 1ns/1ps
interface afd_fast_bus_if
  import afd_pkg::*;
(
  input wire logic clk_i
);
  logic [5:0]  fast_addr_lines;    // address driven by host
  logic        fast_rd;            // host read strobe, one cycle
  logic        fast_wr;            // host write strobe, one cycle
  logic [15:0] fast_data_host;     // host data out
  logic        fast_data_host_oe_n;// low while host drives data
  logic [15:0] fast_data_dev;      // device data out
  logic        fast_data_dev_oe_n; // low while device drives data
  logic        fast_ack;           // device read data valid, one cycle
  logic        block_ready_n;      // low while a record waits
  logic [15:0] fast_data_lines;    // resolved bus level

  // resolve the shared data lines from the enables
  assign fast_data_lines = !fast_data_dev_oe_n  ? fast_data_dev  :
                           !fast_data_host_oe_n ? fast_data_host :
                           16'hFFFF;

  modport dev (
    input  fast_addr_lines, fast_rd, fast_wr, fast_data_lines,
    output fast_data_dev, fast_data_dev_oe_n, fast_ack, block_ready_n
  );
  modport host (
    input  fast_data_lines, fast_ack, block_ready_n,
    output fast_addr_lines, fast_rd, fast_wr, fast_data_host,
           fast_data_host_oe_n
  );
endinterface

// >>> afd_host.sv
// afd_host: fast bus master that runs single reads and writes for a user
// assumes: device answers a read with fast_ack one cycle after the strobe
`timescale 1ns/1ps
module afd_host
  import afd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // fast bus
  afd_fast_bus_if.host     bus,
  // user command port
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [5:0]  cmd_addr_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic      [15:0] rsp_data_o,
  output logic             block_avail_o
);

  typedef struct packed {
    afd_host_state_type st;
    logic [5:0]         addr;
    logic [15:0]        wdata;
    logic               rd;
    logic               wr;
    logic               oe_n;
    logic               ready;
    logic               rvalid;
    logic [15:0]        rdata;
    logic               blk;
  } afd_host_reg_type;

  afd_host_reg_type h_r, h_nxt;

  // command sequencer: one bus cycle per command
  always_comb begin
    h_nxt        = h_r;
    h_nxt.rd     = 1'b0;
    h_nxt.wr     = 1'b0;
    h_nxt.oe_n   = 1'b1;
    h_nxt.rvalid = 1'b0;
    h_nxt.blk    = !bus.block_ready_n;
    unique case (h_r.st)
      AFD_H_IDLE: begin
        if (cmd_valid_i && h_r.ready) begin
          h_nxt.addr  = cmd_addr_i;
          h_nxt.wdata = cmd_wdata_i;
          h_nxt.rd    = !cmd_write_i;
          h_nxt.wr    = cmd_write_i;
          h_nxt.oe_n  = !cmd_write_i;
          h_nxt.ready = 1'b0;
          h_nxt.st    = cmd_write_i ? AFD_H_DONE : AFD_H_WAIT;
        end
      end
      AFD_H_WAIT: begin
        if (bus.fast_ack) begin
          h_nxt.rvalid = 1'b1;
          h_nxt.rdata  = bus.fast_data_lines;
          h_nxt.st     = AFD_H_DONE;
        end
      end
      AFD_H_DONE: begin
        h_nxt.ready = 1'b1;
        h_nxt.st    = AFD_H_IDLE;
      end
      AFD_H_ADDR: h_nxt.st = AFD_H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      h_r       <= '0;
      h_r.st    <= AFD_H_IDLE;
      h_r.oe_n  <= 1'b1;
      h_r.ready <= 1'b1;
    end else begin
      h_r <= h_nxt;
    end
  end

  // bus and user outputs from flip-flops
  assign bus.fast_addr_lines     = h_r.addr;
  assign bus.fast_rd             = h_r.rd;
  assign bus.fast_wr             = h_r.wr;
  assign bus.fast_data_host      = h_r.wdata;
  assign bus.fast_data_host_oe_n = h_r.oe_n;
  assign cmd_ready_o             = h_r.ready;
  assign rsp_valid_o             = h_r.rvalid;
  assign rsp_data_o              = h_r.rdata;
  assign block_avail_o           = h_r.blk;

endmodule

// >>> afd_monitor.sv
// afd_monitor: timing checks on the fast bus between host and device ends
// assumes: placed beside the interface, every signal on clk_i
`timescale 1ns/1ps
module afd_monitor
  import afd_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       reset_i,
  // fast bus signals
  input wire logic [5:0] fast_addr_lines,
  input wire logic       fast_rd,
  input wire logic       fast_wr,
  input wire logic       fast_data_host_oe_n,
  input wire logic       fast_data_dev_oe_n,
  input wire logic       fast_ack,
  input wire logic       block_ready_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // every read is answered in the next cycle
  a_read_gets_ack:
    assert property (fast_rd |=> fast_ack)
    else $error("read strobe left unanswered");
  // an answer only follows a read
  a_ack_from_read:
    assert property (fast_ack |-> $past(fast_rd))
    else $error("answer without a read");
  // device drives the data lines for the answer cycle only
  a_dev_drive_once:
    assert property (fast_ack |-> !fast_data_dev_oe_n ##1 fast_data_dev_oe_n)
    else $error("device drive does not match answer");
  // never both ends on the data lines
  a_no_contention:
    assert property (fast_data_dev_oe_n || fast_data_host_oe_n)
    else $error("both ends drive the data lines");
  // host drives data with each write strobe
  a_write_drives:
    assert property (fast_wr |-> !fast_data_host_oe_n)
    else $error("write strobe without host data");
  // a read occupies the bus for four cycles
  a_read_spacing:
    assert property (fast_rd |=> (!fast_rd && !fast_wr) [*3])
    else $error("strobe too soon after read");
  // write strobe lasts one cycle
  a_write_spacing:
    assert property (fast_wr |=> (!fast_rd && !fast_wr))
    else $error("strobe too soon after write");
  // address held while the read is answered
  a_addr_held:
    assert property (fast_rd |=> $stable(fast_addr_lines))
    else $error("address moved during read");
  // record release only follows a fifo data read
  a_release_on_read:
    assert property ($rose(block_ready_n) |->
      fast_addr_lines == AFD_A_FIFO_DATA &&
      ($past(fast_rd) || $past(fast_rd, 2) || $past(fast_rd, 3)))
    else $error("block ready rose without fifo read");
endmodule

// >>> afd_pkg.sv
// afd_pkg: shared constants and types for the acquisition fifo datapath
// assumes: a single 100 MHz clock, fast bus of 6 address and 16 data lines
package afd_pkg;

  // fast bus widths
  localparam int AFD_ADDR_W = 6;
  localparam int AFD_DATA_W = 16;

  // fast bus address map, word locations
  localparam logic [5:0] AFD_A_FIFO_DATA = 6'h00;
  localparam logic [5:0] AFD_A_TACH_DATA = 6'h01;
  localparam logic [5:0] AFD_A_TACH_PTR  = 6'h02;
  localparam logic [5:0] AFD_A_DECIM     = 6'h03;
  localparam logic [5:0] AFD_A_CONTROL   = 6'h04;
  localparam logic [5:0] AFD_A_TRIG_POS  = 6'h05;
  localparam logic [5:0] AFD_A_SRC_ADDR  = 6'h06;
  localparam logic [5:0] AFD_A_SRC_DATA  = 6'h07;
  localparam logic [5:0] AFD_A_STATUS    = 6'h08;

  // control word fields
  localparam int AFD_CTL_SRC_SEL  = 0;  // input mux: 1 selects source data
  localparam int AFD_CTL_ARM      = 1;  // arm the fifo for a trigger
  localparam int AFD_CTL_SRC_MODE = 2;  // two bits: 0 ram,1 random,2 pink,3 triangle

  // reset values
  localparam logic [15:0] AFD_DECIM_RST    = 16'h0000;
  localparam logic [15:0] AFD_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] AFD_TRIG_POS_RST = 16'h0000;

  // record and ram depths
  localparam int AFD_REC_LEN  = 64;
  localparam int AFD_REC_W    = 6;
  localparam int AFD_TACH_DEP = 16;
  localparam int AFD_TACH_W   = 4;
  localparam int AFD_SRC_DEP  = 64;
  localparam int AFD_SRC_W    = 6;
  localparam int AFD_FILT_DEP = 4;

  // timing: converter reference is divided from the core clock
  localparam int AFD_CLK_MHZ     = 100;
  localparam int AFD_TEN_MHZ     = 10;
  localparam int AFD_TEN_DIV     = AFD_CLK_MHZ / AFD_TEN_MHZ;
  localparam int AFD_XFER_DIV    = 4;  // ten-mhz ticks per converter transfer ref

  // fifo controller states
  typedef enum logic [1:0] {
    AFD_IDLE    = 2'b00,
    AFD_ARMED   = 2'b01,
    AFD_COLLECT = 2'b10,
    AFD_DRAIN   = 2'b11
  } afd_fifo_state_type;

  // host bus sequencer states
  typedef enum logic [1:0] {
    AFD_H_IDLE = 2'b00,
    AFD_H_ADDR = 2'b01,
    AFD_H_WAIT = 2'b10,
    AFD_H_DONE = 2'b11
  } afd_host_state_type;

endpackage
